// ---- testbench/tb.sv ----
// Self-checking testbench of the velocity band mode switch
`timescale 1ns/100ps
`include "vbms_regs.svh"

module tb
  import vbms_pkg::*;
;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  typedef struct {
    vbms_band_t band;
    logic allow, quiet, stop, stall, fs, chm;
    logic [4:0] scale, off;
    logic [3:0] fd, sync;
    logic [8:0] coil, coil_b;
  } vbms_note_t;
  logic        clk_i, sys_rst_i, step_valid_i, small_hyst_i, run;
  logic        adaptive_current_en_i, quiet_pwm_en_i, stall_stop_en_i, stall_out_en_i;
  logic        high_vel_fullstep_en_i, high_vel_chopper_sw_en_i, chopper_mode_cfg_i;
  logic        stall_load_i, stall_speed_i;
  logic [19:0] measured_step_period_i, lower_velocity_threshold_i, high_velocity_threshold_i;
  logic [3:0]  fast_decay_time_cfg_i, sync_cfg_i, off_time_cfg_i, fast_decay_time_o, sync_o;
  logic [4:0]  normal_scale_i, adaptive_scale_i, current_scale_o, off_time_o;
  logic [9:0]  microstep_pos_i;
  logic [8:0]  table_current_a_i, table_current_b_i, coil_a_target_o, coil_b_target_o;
  logic [1:0]  band_o;
  logic        adaptive_current_allow_o, quiet_pwm_o, stall_stop_active_o, stall_o;
  logic        stall_speed_sel_o, fullstep_o, chopper_mode_o;
  vbms_note_t  notes[$];
  vbms_note_t  m;
  vbms_band_t  exp_band;
  logic        exp_lohit, exp_fs;
  logic [8:0]  exp_coil;
  int          n_mismatch, compares;
  int          tp[10] = '{1000, 1060, 1068, 1000, 1060, 5000, 5001, 1001, 0, 0};
  logic        th[10] = '{0, 0, 0, 0, 1, 0, 0, 1, 0, 1};

  vbms_mode_switch vbms_mode_switch_i (.clk_i, .sys_rst_i, .measured_step_period_i,
    .step_valid_i, .lower_velocity_threshold_i, .high_velocity_threshold_i, .small_hyst_i,
    .adaptive_current_en_i, .quiet_pwm_en_i, .stall_stop_en_i, .stall_out_en_i,
    .high_vel_fullstep_en_i, .high_vel_chopper_sw_en_i, .chopper_mode_cfg_i,
    .fast_decay_time_cfg_i, .sync_cfg_i, .off_time_cfg_i, .normal_scale_i, .adaptive_scale_i,
    .microstep_pos_i, .table_current_a_i, .table_current_b_i, .stall_load_i, .stall_speed_i,
    .band_o, .adaptive_current_allow_o, .current_scale_o, .quiet_pwm_o, .stall_stop_active_o,
    .stall_o, .stall_speed_sel_o, .fullstep_o, .coil_a_target_o, .coil_b_target_o,
    .chopper_mode_o, .fast_decay_time_o, .sync_o, .off_time_o);
  vbms_stage_model vbms_stage_model_i (.clk_i, .sys_rst_i, .run_i(run),
    .microstep_pos_o(microstep_pos_i), .table_current_a_o(table_current_a_i),
    .table_current_b_o(table_current_b_i));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Expected outputs from the band, the lower-hit and fullstep flags and the levels now held
  task automatic push_note;
    vbms_note_t n;
    logic sw;
    sw = (exp_band == vbms_band_high) && high_vel_chopper_sw_en_i;
    n.band = exp_band;
    n.allow = adaptive_current_en_i && (exp_band == vbms_band_cool);
    n.scale = n.allow ? adaptive_scale_i : normal_scale_i;
    n.quiet = quiet_pwm_en_i && (exp_band == vbms_band_slow);
    n.stop = stall_stop_en_i && exp_lohit;
    n.stall = exp_lohit && stall_out_en_i && (exp_fs ? stall_speed_i : stall_load_i);
    n.fs = exp_fs;
    n.chm = sw ? 1'b1 : chopper_mode_cfg_i;
    n.fd = sw ? 4'h0 : fast_decay_time_cfg_i;
    n.sync = sw ? 4'h0 : sync_cfg_i;
    n.off = sw ? {off_time_cfg_i, 1'b0} : {1'b0, off_time_cfg_i};
    n.coil = exp_fs ? exp_coil : table_current_a_i; // Table passes through while microstepping
    n.coil_b = exp_fs ? exp_coil : table_current_b_i;
    notes.push_back(n);
  endtask : push_note

  task automatic rand_cfg(input logic fs);
    @(posedge clk_i);
    {adaptive_current_en_i, quiet_pwm_en_i, stall_stop_en_i, stall_out_en_i,
     high_vel_chopper_sw_en_i, chopper_mode_cfg_i, stall_load_i, stall_speed_i} <= 8'($urandom);
    {fast_decay_time_cfg_i, sync_cfg_i, off_time_cfg_i, normal_scale_i, adaptive_scale_i}
      <= 22'($urandom);
    high_vel_fullstep_en_i <= fs;
  endtask : rand_cfg

  // One measurement pulse; the band needs two edges and derived outputs one more
  task automatic measure(input logic [19:0] p, lo, hi, input logic hy);
    logic [19:0] sc;
    logic        uh;
    @(posedge clk_i);
    measured_step_period_i <= p;
    lower_velocity_threshold_i <= lo;
    high_velocity_threshold_i <= hi;
    small_hyst_i <= hy;
    step_valid_i <= 1'b1;
    @(posedge clk_i);
    step_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    sc = (p == 20'h0) ? 20'h0 : p - (hy ? (p >> 5) : (p >> 4)) - 20'h1;
    uh = (exp_band == vbms_band_high) ? (sc <= hi) : (p <= hi);
    exp_lohit = (lo >= p);
    exp_band = uh ? vbms_band_high : (exp_lohit ? vbms_band_cool : vbms_band_slow);
    push_note();
  endtask : measure

  // Runs the sequencer until the low byte reads 0x80, then stops it off that position
  task automatic run_to_45(input logic next_fs);
    int k;
    @(posedge clk_i);
    run <= 1'b1;
    for (k = 0; k < 16 && microstep_pos_i[7:0] !== 8'h80; k++) @(negedge clk_i);
    if (k == 16) begin
      n_mismatch++;
      finish_test();
    end
    exp_coil = table_current_a_i;
    @(posedge clk_i);
    run <= 1'b0;
    repeat (3) @(posedge clk_i);
    exp_fs = next_fs;
    push_note();
  endtask : run_to_45

  // --------------------------------------------------------------------------
  // Clock, watchdog and monitor
  // --------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // A hang counts as a mismatch and ends in the closing report
  initial begin
    repeat (50000) @(posedge clk_i);
    n_mismatch++;
    finish_test();
  end
  // Outputs are settled at the falling edge, so the oldest note is compared there
  always @(negedge clk_i) begin
    if (notes.size() > 0) begin
      m = notes.pop_front();
      check("band_o", band_o, m.band);
      check("adaptive_current_allow_o", adaptive_current_allow_o, m.allow);
      check("current_scale_o", current_scale_o, m.scale);
      check("quiet_pwm_o", quiet_pwm_o, m.quiet);
      check("stall_stop_active_o", stall_stop_active_o, m.stop);
      check("stall_o", stall_o, m.stall);
      check("fullstep_o", fullstep_o, m.fs);
      check("stall_speed_sel_o", stall_speed_sel_o, m.fs);
      check("chopper_mode_o", chopper_mode_o, m.chm);
      check("fast_decay_time_o", fast_decay_time_o, m.fd);
      check("sync_o", sync_o, m.sync);
      check("off_time_o", off_time_o, m.off);
      check("coil_a_target_o", coil_a_target_o, m.coil);
      check("coil_b_target_o", coil_b_target_o, m.coil_b);
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {step_valid_i, small_hyst_i, run, adaptive_current_en_i, quiet_pwm_en_i} = 5'h00;
    {stall_stop_en_i, stall_out_en_i, high_vel_fullstep_en_i} = 3'h0;
    {high_vel_chopper_sw_en_i, chopper_mode_cfg_i, stall_load_i, stall_speed_i} = 4'h0;
    {measured_step_period_i, lower_velocity_threshold_i, high_velocity_threshold_i} = 60'h0;
    {fast_decay_time_cfg_i, sync_cfg_i, off_time_cfg_i, normal_scale_i, adaptive_scale_i} = 22'h0;
    {exp_lohit, exp_fs, exp_coil} = 11'h000;
    exp_band = vbms_band_slow;
    sys_rst_i = 1'b1;
    void'($urandom(43));
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    push_note();
    // Hysteresis edges and exact threshold boundaries, both hysteresis widths
    for (int i = 0; i < 10; i++) begin
      rand_cfg(1'b0);
      measure(tp[i], 20'd5000, 20'd1000, th[i]);
    end
    // Random periods around random thresholds; the fullstep option alone never switches
    for (int i = 0; i < 60; i++) begin
      int hi;
      int lo;
      hi = $urandom_range(64, 4000);
      lo = hi + $urandom_range(0, 4000);
      rand_cfg(1'($urandom));
      measure(20'($urandom_range(0, lo + 200)), 20'(lo), 20'(hi), 1'($urandom));
    end
    // Fullstep entry at 45 degrees in the high band, exit at 45 degrees after slowing
    rand_cfg(1'b1);
    measure(20'd9000, 20'd5000, 20'd1000, 1'b0);
    rand_cfg(1'b1);
    measure(20'd900, 20'd5000, 20'd1000, 1'b0);
    run_to_45(1'b1);
    rand_cfg(1'b1);
    measure(20'd3000, 20'd5000, 20'd1000, 1'b0);
    rand_cfg(1'b1);
    measure(20'd9000, 20'd5000, 20'd1000, 1'b1);
    run_to_45(1'b0);
    repeat (4) @(posedge clk_i);
    finish_test();
  end
endmodule : tb

// ---- testbench/vbms_stage_model.sv ----
// Behavioural model of the power stage side: microstep sequencer and current table
`timescale 1ns/100ps

module vbms_stage_model (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       run_i,
  output logic [9:0]      microstep_pos_o,
  output logic [8:0]      table_current_a_o,
  output logic [8:0]      table_current_b_o
);
  // --------------------------------------------------------------------------
  // Sequencer and table
  // --------------------------------------------------------------------------
  // Steps of 0x40 put the low byte on 0x80 every fourth cycle while running
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      microstep_pos_o <= 10'h000;
    end else if (run_i) begin
      microstep_pos_o <= microstep_pos_o + 10'h040;
    end
  end
  // Every position the sequencer reaches gives another value, so a capture taken off 45 degrees shows up
  assign table_current_a_o = {1'b0, microstep_pos_o[9:2]} ^ 9'h0b3;
  assign table_current_b_o = ~table_current_a_o; // Coil B differs from A on purpose
endmodule : vbms_stage_model

// ---- verilog/vbms_band_cmp.sv ----
// Threshold comparator with hysteresis on the upper velocity threshold
`timescale 1ns/100ps
`include "vbms_regs.svh"

module vbms_band_cmp
  import vbms_pkg::*;
#(
  parameter int STEP_W = `VBMS_STEP_W
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [STEP_W-1:0] measured_step_period_i,
  input  wire logic              step_valid_i,
  input  wire logic [STEP_W-1:0] lower_velocity_threshold_i,
  input  wire logic [STEP_W-1:0] high_velocity_threshold_i,
  input  wire logic              small_hyst_i,
  output logic                   lower_hit_o,
  output logic                   high_hit_o
);

  initial begin
    if (STEP_W < 6) $error("STEP_W too narrow for the hysteresis shift");
  end

  // --------------------------------------------------------------------------
  // Scaled period: p - p/2^sh - 1, floored at zero
  // --------------------------------------------------------------------------
  function automatic logic [STEP_W-1:0] hyst_scale(input logic [STEP_W-1:0] p,
                                                   input logic            fine);
    logic [STEP_W-1:0] part;
    part = fine ? (p >> `VBMS_HYST_SH_FINE) : (p >> `VBMS_HYST_SH_COARSE);
    if (p == '0) begin
      hyst_scale = '0;
    end else begin
      hyst_scale = p - part - {{(STEP_W-1){1'b0}}, 1'b1};
    end
  endfunction : hyst_scale

  logic [STEP_W-1:0] scaled;
  assign scaled = hyst_scale(measured_step_period_i, small_hyst_i); // [RQ9] [RQ10]

  // Lower threshold on the raw period, re-evaluated per measurement
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lower_hit_o <= 1'b0;
    end else if (step_valid_i) begin
      lower_hit_o <= lower_velocity_threshold_i >= measured_step_period_i; // [RQ2] [RQ14]
    end
  end

  // Upper threshold: once inside, the slightly shortened period keeps us there
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      high_hit_o <= 1'b0;
    end else if (step_valid_i) begin
      high_hit_o <= high_hit_o ? (scaled <= high_velocity_threshold_i)   // [RQ9]
                               : (measured_step_period_i <= high_velocity_threshold_i);
    end
  end

  AST_HYST_STAY: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ9]
    step_valid_i && high_hit_o && scaled <= high_velocity_threshold_i |=> high_hit_o)
    else $error("upper band left while inside hysteresis");
  AST_HYST_COARSE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ10]
    step_valid_i && high_hit_o && !small_hyst_i
    && hyst_scale(measured_step_period_i, 1'b0) > high_velocity_threshold_i |=> !high_hit_o)
    else $error("coarse hysteresis not applied");
  AST_HOLD_NO_SAMPLE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ14]
    !step_valid_i |=> $stable(lower_hit_o) && $stable(high_hit_o))
    else $error("band flags changed without a new measurement");

endmodule : vbms_band_cmp

// ---- verilog/vbms_mode_switch.sv ----
// Velocity band mode switch: selects current scaling, chopper and step mode per velocity band
`timescale 1ns/100ps
`include "vbms_regs.svh"

// Behaviour
// RQ1: Between thresholds, adaptive current allowed if enabled; quiet chopper off.
// RQ2: Lower threshold >= period: stop-on-stall and stall output active if enabled.
// RQ3: Period <= high threshold: no adaptive current, normal scale, quiet chopper off.
// RQ4: High band with chopper switch: chopper mode one, fast decay time zero.
// RQ5: High band with chopper switch: synchronisation forced to zero.
// RQ6: High band with fullstep option: fullstep, speed-based stall detection.
// RQ7: Fullstep entry and exit happen only at a 45 degree position.
// RQ8: In fullstep the coil target is the table value at 45 degrees.
// RQ9: Upper compare uses period*15/16-1 or *31/32-1; lower uses raw period.
// RQ10: Hysteresis select low gives one sixteenth, high gives one thirty-second.
// RQ11: Chopper switch active at high velocity doubles the off-time value.
// RQ12: Both options may be active together; without switch chopper mode unchanged.
// RQ13: Quiet chopper enable acts only where the velocity band permits.
// RQ14: Period and thresholds are 20-bit; compared on every new measurement.
module vbms_mode_switch
  import vbms_pkg::*;
#(
  parameter int STEP_W  = `VBMS_STEP_W,
  parameter int POS_W   = `VBMS_POS_W,
  parameter int CUR_W   = `VBMS_CUR_W,
  parameter int SCALE_W = `VBMS_SCALE_W
) (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Measurement and thresholds
  input  wire logic [STEP_W-1:0]       measured_step_period_i,
  input  wire logic                    step_valid_i,
  input  wire logic [STEP_W-1:0]       lower_velocity_threshold_i,
  input  wire logic [STEP_W-1:0]       high_velocity_threshold_i,
  input  wire logic                    small_hyst_i,
  // Feature configuration
  input  wire logic                    adaptive_current_en_i,
  input  wire logic                    quiet_pwm_en_i,
  input  wire logic                    stall_stop_en_i,
  input  wire logic                    stall_out_en_i,
  input  wire logic                    high_vel_fullstep_en_i,
  input  wire logic                    high_vel_chopper_sw_en_i,
  // Chopper configuration
  input  wire logic                    chopper_mode_cfg_i,
  input  wire logic [`VBMS_CFG4_W-1:0] fast_decay_time_cfg_i,
  input  wire logic [`VBMS_CFG4_W-1:0] sync_cfg_i,
  input  wire logic [`VBMS_CFG4_W-1:0] off_time_cfg_i,
  // Current scale and microstep sequencer
  input  wire logic [SCALE_W-1:0]      normal_scale_i,
  input  wire logic [SCALE_W-1:0]      adaptive_scale_i,
  input  wire logic [POS_W-1:0]        microstep_pos_i,
  input  wire logic [CUR_W-1:0]        table_current_a_i,
  input  wire logic [CUR_W-1:0]        table_current_b_i,
  // Stall detectors
  input  wire logic                    stall_load_i,
  input  wire logic                    stall_speed_i,
  // Results
  output logic [1:0]                   band_o,
  output logic                         adaptive_current_allow_o,
  output logic [SCALE_W-1:0]           current_scale_o,
  output logic                         quiet_pwm_o,
  output logic                         stall_stop_active_o,
  output logic                         stall_o,
  output logic                         stall_speed_sel_o,
  output logic                         fullstep_o,
  output logic [CUR_W-1:0]             coil_a_target_o,
  output logic [CUR_W-1:0]             coil_b_target_o,
  output logic                         chopper_mode_o,
  output logic [`VBMS_CFG4_W-1:0]      fast_decay_time_o,
  output logic [`VBMS_CFG4_W-1:0]      sync_o,
  output logic [`VBMS_CFG4_W:0]        off_time_o
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  initial begin
    if (STEP_W != `VBMS_STEP_W) $error("step period width must stay 20 bits");
    if (POS_W < `VBMS_ANGLE_FRAC_W + 2) $error("POS_W too narrow for 45 degree decode");
    if (CUR_W < 1 || SCALE_W < 1) $error("current and scale widths must be positive");
  end

  // --------------------------------------------------------------------------
  // Band decision
  // --------------------------------------------------------------------------
  logic       lower_hit;
  logic       high_hit;
  vbms_band_t band_reg;
  vbms_band_t band_next;

  vbms_band_cmp #(
    .STEP_W (STEP_W)
  ) u_cmp (
    .clk_i                      (clk_i),
    .sys_rst_i                  (sys_rst_i),
    .measured_step_period_i     (measured_step_period_i),
    .step_valid_i               (step_valid_i),
    .lower_velocity_threshold_i (lower_velocity_threshold_i),
    .high_velocity_threshold_i  (high_velocity_threshold_i),
    .small_hyst_i               (small_hyst_i),
    .lower_hit_o                (lower_hit),
    .high_hit_o                 (high_hit)
  );

  // High band wins over the lower one whenever both thresholds are hit
  always_comb begin
    if (high_hit) begin
      band_next = vbms_band_high; // [RQ3]
    end else if (lower_hit) begin
      band_next = vbms_band_cool; // [RQ1]
    end else begin
      band_next = vbms_band_slow;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      band_reg <= vbms_band_slow;
    end else begin
      band_reg <= band_next;
    end
  end

  logic in_high;
  logic in_cool;
  logic chsw_act;
  logic at_45;
  assign in_high  = (band_reg == vbms_band_high);
  assign in_cool  = (band_reg == vbms_band_cool);
  assign chsw_act = in_high && high_vel_chopper_sw_en_i; // [RQ4] [RQ12]
  assign at_45    = (microstep_pos_i[`VBMS_ANGLE_FRAC_W-1:0] == `VBMS_ANGLE_45); // [RQ7]

  // --------------------------------------------------------------------------
  // Current scaling and quiet chopper
  // --------------------------------------------------------------------------
  // Adaptive scaling only in the middle band; elsewhere normal scale
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      adaptive_current_allow_o <= 1'b0;
      current_scale_o          <= '0;
    end else begin
      adaptive_current_allow_o <= in_cool && adaptive_current_en_i; // [RQ1] [RQ3]
      current_scale_o          <= (in_cool && adaptive_current_en_i) ? adaptive_scale_i
                                                                     : normal_scale_i; // [RQ3]
    end
  end

  // Quiet chopper only below both thresholds, so mode follows the band
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      quiet_pwm_o <= 1'b0;
    end else begin
      quiet_pwm_o <= quiet_pwm_en_i && (band_reg == vbms_band_slow); // [RQ1] [RQ3] [RQ13]
    end
  end

  // --------------------------------------------------------------------------
  // Stall handling
  // --------------------------------------------------------------------------
  // Stall features follow the lower threshold in the high band too
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stall_stop_active_o <= 1'b0;
      stall_o             <= 1'b0;
    end else begin
      stall_stop_active_o <= lower_hit && stall_stop_en_i; // [RQ2]
      stall_o             <= lower_hit && stall_out_en_i
                             && (fullstep_o ? stall_speed_i : stall_load_i); // [RQ2] [RQ6]
    end
  end

  // --------------------------------------------------------------------------
  // Fullstep switch
  // --------------------------------------------------------------------------
  // Changing mode away from 45 degrees would jump the coil currents
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fullstep_o <= 1'b0;
    end else if (at_45) begin
      fullstep_o <= in_high && high_vel_fullstep_en_i; // [RQ6] [RQ7]
    end
  end

  assign stall_speed_sel_o = fullstep_o; // [RQ6]

  // Table value captured at each 45 degree point, held through fullstep
  logic [CUR_W-1:0] hold_current_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_current_reg <= '0;
    end else if (at_45) begin
      hold_current_reg <= table_current_a_i; // [RQ8]
    end
  end

  // Coil targets: the table in microstep mode, the 45 degree value in fullstep
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      coil_a_target_o <= '0;
      coil_b_target_o <= '0;
    end else begin
      coil_a_target_o <= fullstep_o ? hold_current_reg : table_current_a_i; // [RQ8]
      coil_b_target_o <= fullstep_o ? hold_current_reg : table_current_b_i; // [RQ8]
    end
  end

  // --------------------------------------------------------------------------
  // Chopper overrides
  // --------------------------------------------------------------------------
  // Off-time doubled so the slow-decay chopper keeps its frequency
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chopper_mode_o    <= 1'b0;
      fast_decay_time_o <= '0;
      sync_o            <= '0;
      off_time_o        <= '0;
    end else if (chsw_act) begin
      chopper_mode_o    <= `VBMS_FORCE_CHM;              // [RQ4]
      fast_decay_time_o <= `VBMS_FORCE_FD;               // [RQ4]
      sync_o            <= `VBMS_FORCE_SYNC;             // [RQ5]
      off_time_o        <= {off_time_cfg_i, 1'b0};       // [RQ11]
    end else begin
      chopper_mode_o    <= chopper_mode_cfg_i;           // [RQ12]
      fast_decay_time_o <= fast_decay_time_cfg_i;
      sync_o            <= sync_cfg_i;
      off_time_o        <= {1'b0, off_time_cfg_i};
    end
  end

  assign band_o = band_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_COOL_ALLOW: assert property ( // [RQ1]
    in_cool && adaptive_current_en_i |=> adaptive_current_allow_o && !quiet_pwm_o)
    else $error("adaptive current not allowed in middle band");

  AST_STALL_STOP: assert property ( // [RQ2]
    lower_hit |=> stall_stop_active_o == $past(stall_stop_en_i))
    else $error("stop-on-stall does not follow lower threshold");

  AST_STALL_GATED: assert property ( // [RQ2]
    !lower_hit |=> !stall_o && !stall_stop_active_o)
    else $error("stall signalled above lower threshold period");

  AST_HIGH_NORMAL: assert property ( // [RQ3]
    in_high |=> !adaptive_current_allow_o && !quiet_pwm_o
             && current_scale_o == $past(normal_scale_i))
    else $error("high band not at normal scale");

  AST_CHSW_MODE: assert property ( // [RQ4]
    chsw_act |=> chopper_mode_o && fast_decay_time_o == '0)
    else $error("constant off-time chopper not forced");

  AST_CHSW_SYNC: assert property ( // [RQ5]
    chsw_act |=> sync_o == '0)
    else $error("synchronisation not switched off");

  AST_FS_ENTRY: assert property ( // [RQ6]
    $rose(fullstep_o) |-> $past(in_high && high_vel_fullstep_en_i))
    else $error("fullstep entered outside high band or without option");

  AST_FS_NO_OPT: assert property ( // [RQ6]
    at_45 && !high_vel_fullstep_en_i |=> !fullstep_o [*2])
    else $error("fullstep with option cleared");

  AST_FS_AT_45: assert property ( // [RQ7]
    fullstep_o != $past(fullstep_o) |-> $past(at_45))
    else $error("fullstep transition away from 45 degrees");

  AST_FS_CURRENT: assert property ( // [RQ8]
    fullstep_o |=> coil_a_target_o == $past(hold_current_reg)
               && coil_b_target_o == $past(hold_current_reg))
    else $error("fullstep coil target not the 45 degree value");

  AST_OFF_DOUBLE: assert property ( // [RQ11]
    chsw_act |=> off_time_o == {$past(off_time_cfg_i), 1'b0})
    else $error("off-time not doubled");

  AST_NO_CHSW: assert property ( // [RQ12]
    !chsw_act |=> chopper_mode_o == $past(chopper_mode_cfg_i)
              && off_time_o == {1'b0, $past(off_time_cfg_i)})
    else $error("chopper mode changed without switch option");

  AST_QUIET_BAND: assert property ( // [RQ13]
    quiet_pwm_o |-> $past(band_reg) == vbms_band_slow)
    else $error("quiet chopper outside permitted band");

  AST_BAND_LAT: assert property ( // [RQ14]
    step_valid_i && measured_step_period_i <= high_velocity_threshold_i
    |=> ##1 band_reg == vbms_band_high)
    else $error("band not updated after measurement");

  COV_HIGH: cover property (in_high ##1 in_high);
  COV_COOL: cover property (in_cool && adaptive_current_en_i);
  COV_FS:   cover property ($rose(fullstep_o));
  COV_BOTH: cover property (chsw_act && fullstep_o);

endmodule : vbms_mode_switch

// ---- verilog/vbms_pkg.sv ----
// Types shared by the velocity band mode switch
package vbms_pkg;

  // --------------------------------------------------------------------------
  // Velocity band, slowest to fastest
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    vbms_band_slow = 2'b00,
    vbms_band_cool = 2'b01,
    vbms_band_high = 2'b10
  } vbms_band_t;

endpackage : vbms_pkg

// ---- verilog/vbms_regs.svh ----
// Constants of the velocity band mode switch: widths, hysteresis shifts, angle decode, reset and forced values
`ifndef VBMS_REGS_SVH
`define VBMS_REGS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define VBMS_STEP_W        20
`define VBMS_POS_W         10
`define VBMS_CUR_W         9
`define VBMS_CFG4_W        4
`define VBMS_SCALE_W       5

// ----------------------------------------------------------------------------
// Hysteresis shifts, angle decode, reset and forced values
// ----------------------------------------------------------------------------
`define VBMS_HYST_SH_COARSE 5'd4
`define VBMS_HYST_SH_FINE   5'd5
`define VBMS_ANGLE_FRAC_W   8
`define VBMS_ANGLE_45       8'h80
`define VBMS_RST_STEP       20'hfffff
`define VBMS_FORCE_CHM      1'b1
`define VBMS_FORCE_FD       4'h0
`define VBMS_FORCE_SYNC     4'h0

`endif
